//--- cmdio_card_end.sv
// Purpose: Peripheral card end: command decode, data return, daisy-chained interrupt.
// Assumes: Bus signals come from logic on the same core clock.
// Notes: All bus drives are registered, so each lags its cause by one core clock.
`timescale 1ns/100ps
module cmdio_card_end
  import cmdio_pkg::*;
#(
  parameter logic [5:0] DEV_IN = DEV_IN_DEFAULT,
  parameter logic [5:0] DEV_OUT = DEV_OUT_DEFAULT,
  parameter bit USE_INT = 1'b1
)
(
  input wire logic i_core_clk,
  input wire logic i_nrst,
  cmdio_bus_if.card bus,
  input wire logic [7:0] i_in_data,
  input wire logic i_int_req,
  input wire logic [7:0] i_int_instr,
  output logic [7:0] o_out_data,
  output logic o_out_strobe,
  output logic o_in_taken,
  output logic o_int_pending,
  output logic o_int_served
);

  typedef struct packed {
    logic c3_prev;
    logic in_hit;
    int_state_e ist;
    logic [7:0] instr;
    logic own_int;
    logic int_out_n;
    logic [7:0] dout_n;
    logic [7:0] doe_n;
    logic [7:0] out_data;
    logic out_stb;
    logic in_taken;
    logic served;
    logic pend;
  } card_s;

  card_s cur_r;
  card_s cur_nxt;
  logic [15:0] addr;
  logic cmd;
  logic ack;
  logic is_in;
  logic in_hit;
  logic out_hit;
  logic c3_rise;
  logic c3_fall;
  logic [5:0] in_dev;
  logic [5:0] out_dev;

  // --------------------------------------------------------------------------
  // Command decode
  // --------------------------------------------------------------------------
  always_comb
  begin
    addr = ~bus.addr_n;
    cmd = ~bus.cmd_io_n;
    ack = ~bus.int_ack_win_n;
    // output unless bits 12,13 both zero
    is_in = (addr[DIR_HI:DIR_LO] == DIR_INPUT);
    in_dev = {addr[IN_DEV_HI:IN_DEV_LO], addr[DEV_HI:DEV_LO]};
    out_dev = {addr[OUT_DEV_HI:OUT_DEV_LO], addr[DEV_HI:DEV_LO]};
    in_hit = cmd && is_in && (in_dev == DEV_IN);
    out_hit = cmd && !is_in && (out_dev == DEV_OUT);
    c3_rise = bus.clk3 && !cur_r.c3_prev;
    c3_fall = !bus.clk3 && cur_r.c3_prev;
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb
  begin
    cur_nxt = cur_r;
    cur_nxt.c3_prev = bus.clk3;
    cur_nxt.in_hit = in_hit;
    cur_nxt.out_stb = 1'b0;
    cur_nxt.served = 1'b0;
    cur_nxt.in_taken = in_hit && !cur_r.in_hit;

    // Output capture at clock 3 rise, where the byte is surely settled
    // sample inside the stable window
    if (out_hit && c3_rise)
    begin
      cur_nxt.out_data = addr[DATA_HI:0];
      cur_nxt.out_stb = 1'b1;
    end

    // Interrupt sequence
    case (cur_r.ist)
      INT_IDLE:
      begin
        if (USE_INT && i_int_req)
        begin
          cur_nxt.ist = INT_PEND;
          cur_nxt.instr = i_int_instr;
        end
      end
      INT_PEND:
      begin
        // assert on clock 3 lagging edge
        if (c3_fall)
        begin
          cur_nxt.ist = INT_RAISED;
          cur_nxt.own_int = 1'b1;
        end
      end
      INT_RAISED:
      begin
        if (ack)
        begin
          cur_nxt.ist = INT_ACK;
          cur_nxt.own_int = 1'b0;
        end
      end
      INT_ACK:
      begin
        if (!ack)
        begin
          cur_nxt.ist = INT_IDLE;
          cur_nxt.served = 1'b1;
        end
      end
      default:
      begin
        cur_nxt.ist = INT_IDLE;
        cur_nxt.own_int = 1'b0;
      end
    endcase
    // Registered so the pending output comes straight from a flop
    cur_nxt.pend = (cur_nxt.ist != INT_IDLE);

    // Chain output: own request or upstream request
    if (USE_INT)
    begin
      cur_nxt.int_out_n = bus.int_chain_in_n && !cur_nxt.own_int;
    end
    else
    begin
      cur_nxt.int_out_n = bus.int_chain_in_n;
    end

    // Data bus drive; input and acknowledge never overlap on the processor side
    if (in_hit)
    begin
      cur_nxt.dout_n = ~i_in_data;
      cur_nxt.doe_n = 8'h00;
    end
    else if (ack && (cur_r.ist == INT_RAISED || cur_r.ist == INT_ACK))
    begin
      cur_nxt.dout_n = ~cur_r.instr;
      cur_nxt.doe_n = 8'h00;
    end
    else
    begin
      // release bus at strobe or window end
      cur_nxt.dout_n = DATA_IDLE_N;
      cur_nxt.doe_n = DATA_IDLE_N;
    end
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      cur_r <= '{ist: INT_IDLE, int_out_n: 1'b1, dout_n: DATA_IDLE_N,
                 doe_n: DATA_IDLE_N, default: '0};
    end
    else
    begin
      cur_r <= cur_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign bus.card_data_o_n = cur_r.dout_n;
  assign bus.card_data_oe_n = cur_r.doe_n;
  assign bus.int_out_n = cur_r.int_out_n;
  assign o_out_data = cur_r.out_data;
  assign o_out_strobe = cur_r.out_stb;
  assign o_in_taken = cur_r.in_taken;
  // Pending covers request latched through acknowledge end
  assign o_int_pending = cur_r.pend;
  assign o_int_served = cur_r.served;

endmodule

//--- cmdio_pkg.sv
// Purpose: Shared constants and types for the command I/O and interrupt bus.
// Assumes: One 125 MHz core clock; a memory cycle is a whole number of core clocks.
// Notes: Bus lines are ground true; the _n values held here are wire levels.
package cmdio_pkg;

  // --------------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------------
  localparam int unsigned CORE_CLK_NS = 8;
  localparam int unsigned MEM_CYCLE_NS = 96;
  localparam int unsigned CYC_LEN = MEM_CYCLE_NS / CORE_CLK_NS;
  localparam logic [3:0] PH_LAST = 4'(CYC_LEN - 1);
  localparam logic [3:0] PH_FIRST = 4'h0;
  localparam logic [3:0] C1_ON = 4'h1;
  localparam logic [3:0] C2_ON = 4'h5;
  localparam logic [3:0] C3_ON = 4'h9;

  // --------------------------------------------------------------------------
  // Address fields
  // --------------------------------------------------------------------------
  localparam int DIR_LO = 12;
  localparam int DIR_HI = 13;
  localparam int DEV_LO = 8;
  localparam int DEV_HI = 11;
  localparam int IN_DEV_LO = 6;
  localparam int IN_DEV_HI = 7;
  localparam int OUT_DEV_LO = 14;
  localparam int OUT_DEV_HI = 15;
  localparam int DATA_HI = 7;
  localparam logic [1:0] DIR_INPUT = 2'h0;
  localparam logic [1:0] DIR_OUTPUT = 2'h1;

  // --------------------------------------------------------------------------
  // Reset and idle values
  // --------------------------------------------------------------------------
  localparam logic [15:0] ADDR_IDLE_N = 16'hFFFF;
  localparam logic [7:0] DATA_IDLE_N = 8'hFF;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [5:0] DEV_IN_DEFAULT = 6'h21;
  localparam logic [5:0] DEV_OUT_DEFAULT = 6'h21;

  // --------------------------------------------------------------------------
  // States
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    CPU_IDLE = 2'b00,
    CPU_CMD = 2'b01,
    CPU_HOLD = 2'b10,
    CPU_ACK = 2'b11
  } cpu_state_e;

  typedef enum logic [1:0] {
    INT_IDLE = 2'b00,
    INT_PEND = 2'b01,
    INT_RAISED = 2'b10,
    INT_ACK = 2'b11
  } int_state_e;

endpackage

//--- cmdio_bus_if.sv
// Purpose: System bus wires between processor end and one peripheral card.
// Assumes: Open-collector data bus with pull-ups; only the card drives data here.
// Notes: Output enables are active low; an idle line reads high (logic zero).
`timescale 1ns/100ps
interface cmdio_bus_if;
  logic [15:0] addr_n;
  logic cmd_io_n;
  logic bus_req_n;
  logic clk1;
  logic clk2;
  logic clk3;
  logic int_ack_win_n;
  logic int_chain_in_n;
  logic int_out_n;
  logic [7:0] card_data_o_n;
  logic [7:0] card_data_oe_n;
  logic [7:0] data_n;

  // --------------------------------------------------------------------------
  // Wired bus level
  // --------------------------------------------------------------------------
  // Per bit: pulled up unless enabled and pulled low
  assign data_n = card_data_o_n | card_data_oe_n;

  modport cpu (
    output addr_n, cmd_io_n, bus_req_n, clk1, clk2, clk3, int_ack_win_n,
    input data_n, int_out_n
  );

  modport card (
    input addr_n, cmd_io_n, bus_req_n, clk1, clk2, clk3, int_ack_win_n,
    input data_n, int_chain_in_n,
    output card_data_o_n, card_data_oe_n, int_out_n
  );
endinterface

//--- cmdio_cpu_end.sv
// Purpose: Processor end: phase clocks, command I/O cycles, interrupt acknowledge.
// Assumes: Card logic runs on the same core clock, so no synchronisers.
// Notes: One command or acknowledge per memory cycle, then one idle cycle.
`timescale 1ns/100ps
module cmdio_cpu_end
  import cmdio_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_nrst,
  cmdio_bus_if.cpu bus,
  input wire logic i_cmd_req,
  input wire logic i_cmd_output,
  input wire logic [5:0] i_dev_num,
  input wire logic [7:0] i_acc,
  output logic o_busy,
  output logic o_done,
  output logic [7:0] o_in_data,
  output logic [7:0] o_int_instr,
  output logic o_int_valid
);

  typedef struct packed {
    logic [3:0] ph;
    logic c1;
    logic c2;
    logic c3;
    cpu_state_e st;
    logic [15:0] addr_n;
    logic cmd_n;
    logic req_n;
    logic ack_n;
    logic busy;
    logic is_out;
    logic [5:0] dev;
    logic [7:0] acc;
    logic done;
    logic [7:0] in_data;
    logic [7:0] instr;
    logic ivalid;
  } cpu_s;

  cpu_s cur_r;
  cpu_s cur_nxt;
  logic cyc_end;
  logic [15:0] cmd_addr;

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb
  begin
    cur_nxt = cur_r;
    cur_nxt.done = 1'b0;
    cur_nxt.ivalid = 1'b0;
    cyc_end = (cur_r.ph == PH_LAST);
    cur_nxt.ph = cyc_end ? PH_FIRST : cur_r.ph + 4'h1;
    cur_nxt.c1 = (cur_nxt.ph >= C1_ON) && (cur_nxt.ph < C2_ON);
    cur_nxt.c2 = (cur_nxt.ph >= C2_ON) && (cur_nxt.ph < C3_ON);
    cur_nxt.c3 = (cur_nxt.ph >= C3_ON);
    cmd_addr = 16'h0000;
    cmd_addr[DIR_HI:DIR_LO] = cur_r.is_out ? DIR_OUTPUT : DIR_INPUT;
    cmd_addr[DEV_HI:DEV_LO] = cur_r.dev[3:0];
    cmd_addr[DATA_HI:0] = cur_r.acc;
    // upper device bits ride on accumulator for input; output puts dev[5:4] in bits 15:14
    if (cur_r.is_out)
    begin
      cmd_addr[OUT_DEV_HI:OUT_DEV_LO] = cur_r.dev[5:4];
    end
    if (i_cmd_req && !cur_r.busy)
    begin
      cur_nxt.busy = 1'b1;
      cur_nxt.is_out = i_cmd_output;
      cur_nxt.dev = i_dev_num;
      cur_nxt.acc = i_acc;
    end
    case (cur_r.st)
      CPU_IDLE:
      begin
        if (cyc_end && cur_r.busy)
        begin
          cur_nxt.st = CPU_CMD;
          cur_nxt.addr_n = ~cmd_addr;
          cur_nxt.cmd_n = 1'b0;
          cur_nxt.req_n = 1'b0;
        end
        else if (cyc_end && !bus.int_out_n)
        begin
          cur_nxt.st = CPU_ACK;
          cur_nxt.ack_n = 1'b0;
          cur_nxt.req_n = 1'b0;
        end
      end
      CPU_CMD:
      begin
        if (cyc_end)
        begin
          cur_nxt.st = CPU_HOLD;
          cur_nxt.cmd_n = 1'b1;
          cur_nxt.req_n = 1'b1;
          cur_nxt.done = 1'b1;
          if (!cur_r.is_out)
          begin
            cur_nxt.in_data = ~bus.data_n;
          end
        end
      end
      CPU_HOLD:
      begin
        // address held past clock 3 lag
        cur_nxt.st = CPU_IDLE;
        cur_nxt.addr_n = ADDR_IDLE_N;
        cur_nxt.busy = 1'b0;
      end
      CPU_ACK:
      begin
        if (cyc_end)
        begin
          cur_nxt.st = CPU_IDLE;
          cur_nxt.ack_n = 1'b1;
          cur_nxt.req_n = 1'b1;
          cur_nxt.instr = ~bus.data_n;
          cur_nxt.ivalid = 1'b1;
        end
      end
      default:
      begin
        cur_nxt.st = CPU_IDLE;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      cur_r <= '{ph: PH_FIRST, st: CPU_IDLE, addr_n: ADDR_IDLE_N, cmd_n: 1'b1,
                 req_n: 1'b1, ack_n: 1'b1, default: '0};
    end
    else
    begin
      cur_r <= cur_nxt;
    end
  end

  assign bus.addr_n = cur_r.addr_n;
  assign bus.cmd_io_n = cur_r.cmd_n;
  assign bus.bus_req_n = cur_r.req_n;
  assign bus.clk1 = cur_r.c1;
  assign bus.clk2 = cur_r.c2;
  assign bus.clk3 = cur_r.c3;
  assign bus.int_ack_win_n = cur_r.ack_n;
  assign o_busy = cur_r.busy;
  assign o_done = cur_r.done;
  assign o_in_data = cur_r.in_data;
  assign o_int_instr = cur_r.instr;
  assign o_int_valid = cur_r.ivalid;

endmodule

//--- cmdio_bus_monitor.sv
// Purpose: Bus checker beside the wires joining processor end and card end.
// Assumes: One core clock; card selected by device number DEV.
// Notes: Address seen in logic sense, so the wire is inverted first.
`timescale 1ns/100ps
module cmdio_bus_monitor #(
  parameter logic [5:0] DEV = 6'h21
)
(
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic [15:0] addr_n,
  input wire logic cmd_io_n,
  input wire logic bus_req_n,
  input wire logic clk1,
  input wire logic clk3,
  input wire logic int_ack_win_n,
  input wire logic int_out_n,
  input wire logic [7:0] card_data_oe_n
);
  logic [15:0] dec;
  logic in_sel;
  assign dec = ~addr_n;
  // Bits 7:6 join the device number
  assign in_sel = (dec[13:12] == 2'h0) && ({dec[7:6], dec[11:8]} == DEV);

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);

  a_claim_with_strobe: assert property (!cmd_io_n |-> !bus_req_n)
    else $error("bus claim missing during strobe");
  a_strobe_one_cycle: assert property ($fell(cmd_io_n) |-> ##11 !cmd_io_n ##1 cmd_io_n)
    else $error("strobe length wrong");
  a_strobe_before_clk1: assert property ($fell(cmd_io_n) |=> $rose(clk1))
    else $error("strobe not ahead of clock 1");
  a_addr_steady: assert property (!cmd_io_n && !$fell(cmd_io_n) |-> $stable(addr_n))
    else $error("address moved in strobe");
  a_addr_past_clk3: assert property ($rose(cmd_io_n) |-> $stable(addr_n))
    else $error("address dropped too early");
  a_input_drive: assert property ($fell(cmd_io_n) && in_sel |=> (card_data_oe_n == 8'h00)[*8])
    else $error("selected card not driving");
  a_foreign_quiet: assert property (!cmd_io_n && !in_sel |-> card_data_oe_n == 8'hFF)
    else $error("card drove while not selected");
  a_bus_release: assert property ($rose(cmd_io_n) || $rose(int_ack_win_n) |=>
    card_data_oe_n == 8'hFF)
    else $error("data bus not released");
  a_int_at_clk3: assert property ($fell(int_out_n) |-> !clk3 && ($past(clk3) || $past(clk3, 2)))
    else $error("interrupt not at clock 3 lag");
  a_int_drop_ack: assert property ($fell(int_ack_win_n) |-> ##[1:2] int_out_n)
    else $error("interrupt held in window");
  a_instr_drive: assert property ($fell(int_ack_win_n) |-> ##[1:2] (card_data_oe_n == 8'h00)[*8])
    else $error("instruction not driven");

  c_input_cmd: cover property ($fell(cmd_io_n) && in_sel);
  c_output_cmd: cover property ($fell(cmd_io_n) && dec[13:12] == 2'h1);
  c_ack_window: cover property ($fell(int_ack_win_n));
endmodule

//--- command_io_interrupt_port_tb_top.sv
// Purpose: Drives both ends through their user ports and checks results.
// Assumes: Card number 6'h21; second card without interrupts on its own bus.
// Notes: Inputs change at the falling edge only.
`timescale 1ns/100ps
module command_io_interrupt_port_tb_top;
  import cmdio_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic cmd_req = 1'b0;
  logic cmd_output = 1'b0;
  logic [5:0] dev_num = 6'h00;
  logic [7:0] acc = 8'h00;
  logic [7:0] in_data = 8'hA5;
  logic int_req = 1'b0;
  logic [7:0] int_instr = 8'hD7;
  logic busy, done, int_valid, out_strobe, in_taken, int_pending, int_served;
  logic [7:0] cpu_in, cpu_instr, out_data, seen_data;
  logic [15:0] seen_addr;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;
  int out_cnt = 0;
  int in_cnt = 0;
  int served = 0;
  int pass_low = 0;
  int n;
  cmdio_bus_if bus ();
  cmdio_bus_if bus_b ();
  assign bus.int_chain_in_n = 1'b1;
  // Second card sees the same commands and clocks but no acknowledge window; its chain input is the first card
  assign bus_b.addr_n = bus.addr_n;
  assign bus_b.cmd_io_n = bus.cmd_io_n;
  assign bus_b.bus_req_n = bus.bus_req_n;
  assign bus_b.clk1 = bus.clk1;
  assign bus_b.clk2 = bus.clk2;
  assign bus_b.clk3 = bus.clk3;
  assign bus_b.int_ack_win_n = 1'b1;
  assign bus_b.int_chain_in_n = bus.int_out_n;

  cmdio_cpu_end u_cmdio_cpu_end (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .bus(bus),
    .i_cmd_req(cmd_req), .i_cmd_output(cmd_output), .i_dev_num(dev_num), .i_acc(acc),
    .o_busy(busy), .o_done(done), .o_in_data(cpu_in), .o_int_instr(cpu_instr),
    .o_int_valid(int_valid));
  cmdio_card_end u_cmdio_card_end (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .bus(bus),
    .i_in_data(in_data), .i_int_req(int_req), .i_int_instr(int_instr),
    .o_out_data(out_data), .o_out_strobe(out_strobe), .o_in_taken(in_taken),
    .o_int_pending(int_pending), .o_int_served(int_served));
  cmdio_card_end #(.USE_INT(1'b0)) u_cmdio_card_end_pass (.i_core_clk(i_core_clk),
    .i_nrst(i_nrst), .bus(bus_b), .i_in_data(in_data), .i_int_req(int_req),
    .i_int_instr(int_instr), .o_out_data(), .o_out_strobe(), .o_in_taken(),
    .o_int_pending(), .o_int_served());
  cmdio_bus_monitor #(.DEV(6'h21)) u_cmdio_bus_monitor (.i_core_clk(i_core_clk),
    .i_nrst(i_nrst), .addr_n(bus.addr_n), .cmd_io_n(bus.cmd_io_n),
    .bus_req_n(bus.bus_req_n), .clk1(bus.clk1), .clk3(bus.clk3),
    .int_ack_win_n(bus.int_ack_win_n), .int_out_n(bus.int_out_n),
    .card_data_oe_n(bus.card_data_oe_n));

  // --------------------------------------------------------------------------
  // Clock, watch and tasks
  // --------------------------------------------------------------------------
  initial
  begin
    forever #4 i_core_clk = ~i_core_clk;
  end

  // Last strobe cycle wins, so captures hold the settled values
  always @(posedge i_core_clk)
  begin
    cycles++;
    if (out_strobe === 1'b1) out_cnt++;
    if (in_taken === 1'b1) in_cnt++;
    if (int_served === 1'b1) served++;
    if (bus_b.int_out_n === 1'b0) pass_low++;
    if (bus.cmd_io_n === 1'b0) seen_addr = bus.addr_n;
    if (bus.cmd_io_n === 1'b0) seen_data = bus.data_n;
    if (cycles == 5000)
    begin
      mismatches++;
      wrap_up();
    end
  end

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic cmd(input logic o, input logic [5:0] d, input logic [7:0] a);
    @(negedge i_core_clk);
    cmd_output = o;
    dev_num = d;
    acc = a;
    cmd_req = 1'b1;
    @(negedge i_core_clk);
    cmd_req = 1'b0;
    chk("busy_set", 16'h0001, 16'(busy));
    n = 0;
    while (done !== 1'b1 && n < 40)
    begin
      @(negedge i_core_clk);
      n++;
    end
    chk("done", 16'h0001, 16'(done));
    @(negedge i_core_clk);
    chk("busy_clear", 16'h0000, 16'(busy));
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // --------------------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------------------
  initial
  begin
    repeat (10) @(negedge i_core_clk);
    i_nrst = 1'b1;
    cmd(1'b0, 6'h21, 8'h9C);
    chk("in_data", 16'h00A5, 16'(cpu_in));
    chk("in_wire", 16'h005A, 16'(seen_data));
    chk("in_addr", 16'h019C, ~seen_addr);
    in_data = 8'h3C;
    cmd(1'b0, 6'h21, 8'h1C);
    chk("in_bits76", 16'h0000, 16'(cpu_in));
    cmd(1'b0, 6'h22, 8'h9C);
    chk("in_other", 16'h0001, 16'(in_cnt));
    cmd(1'b1, 6'h21, 8'h5A);
    chk("out_data", 16'h005A, 16'(out_data));
    chk("out_addr", 16'h915A, ~seen_addr);
    chk("out_wire", 16'h00FF, 16'(seen_data));
    cmd(1'b1, 6'h11, 8'hC3);
    chk("out_other", 16'h0001, 16'(out_cnt));
    chk("out_keep", 16'h005A, 16'(out_data));
    @(negedge i_core_clk);
    int_req = 1'b1;
    @(negedge i_core_clk);
    int_instr = 8'hFF;
    chk("pending", 16'h0001, 16'(int_pending));
    @(negedge i_core_clk);
    int_req = 1'b0;
    n = 0;
    while (int_valid !== 1'b1 && n < 80)
    begin
      @(negedge i_core_clk);
      n++;
    end
    chk("instr", 16'h00D7, 16'(cpu_instr));
    repeat (4) @(negedge i_core_clk);
    chk("int_out", 16'h0001, 16'(bus.int_out_n));
    chk("served", 16'h0001, 16'(served));
    chk("chain_seen", 16'h0001, 16'(pass_low > 0));
    chk("chain_idle", 16'h0001, 16'(bus_b.int_out_n));
    chk("pend_clear", 16'h0000, 16'(int_pending));
    wrap_up();
  end
endmodule
